/* File: hdl/true_random_byte_source.sv */
// random byte source: noise sampling, optional bias removal, byte packing, registers, interrupt
// assumes noise_bit comes from an analog noise cell outside this clock domain
//
// Function
// - a one written to the start trigger begins generation, with no seed needed.
// - a one written to the stop trigger halts generation.
// - while running, bytes keep coming and each goes to the output register when complete.
// - every byte loaded into the output register raises the sample-ready event once.
// - with bias correction on, the raw bit stream is cleaned of any lean toward ones or zeros.
// - accepted bits shift into an eight-bit holder that moves in parallel to the output register.
// - a setup bit turns bias correction on or off, trading speed for uniform output.
// - the time per byte varies, so software assumes no fixed rate.
// - the flag register reads one after a new byte and zero otherwise, and a write of one clears it.
// - with the shortcut bit set, the sample-ready event stops generation; it resets to zero.
// - output comes from physical noise, not from a pseudo-random sequence.
// - a one written to the enable-set register enables the interrupt; a zero does nothing.
// - a one written to the enable-clear register disables it; both read back the enable.
//
// The implementer's own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "noise_byte_regs.svh"

module true_random_byte_source #(
   parameter int unsigned SAMPLE_DIV = `SAMPLE_DIV_DEFAULT
) (
   input  wire logic                  clk_sys,
   input  wire logic                  rst_n,
   input  wire logic                  noise_bit,
   input  wire noise_byte_pkg::avl_req_t bus_req,
   output var  noise_byte_pkg::avl_rsp_t bus_rsp,
   output var  logic                  irq
);
   import noise_byte_pkg::*;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic hit(input logic [11:0] addr, input logic [11:0] ofs);
      hit = (addr[11:2] == ofs[11:2]);
   endfunction

   function automatic logic [31:0] bit_word(input logic b);
      bit_word = {31'h0000_0000, b};
   endfunction

   state_t s;
   state_t next_s;
   logic   wr_acc;
   logic   wr_one;
   logic   start_hit;
   logic   stop_hit;
   logic   strobe;
   logic   accept;
   logic   acc_bit;
   logic   byte_done;
   logic [7:0] new_byte;

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      next_s    = s;
      strobe    = 1'b0;
      accept    = 1'b0;
      acc_bit   = 1'b0;
      byte_done = 1'b0;
      new_byte  = {s.shift[6:0], s.noise_s2};

      // two-flop synchroniser for the noise pin
      // physical noise
      next_s.noise_s1 = noise_bit;
      next_s.noise_s2 = s.noise_s1;

      // bus handshake: one wait cycle, then one cycle with waitrequest low
      // a held request lands once, in the cycle with waitrequest low
      wr_acc    = bus_req.write && !s.rsp.waitrequest && bus_req.byteenable[0];
      wr_one    = wr_acc && bus_req.writedata[0];
      start_hit = wr_one && hit(bus_req.address, `OFS_START_TRIGGER);
      stop_hit  = wr_one && hit(bus_req.address, `OFS_STOP_TRIGGER);
      next_s.rsp.waitrequest = !((bus_req.read || bus_req.write) && s.rsp.waitrequest);

      // sample divider runs only while generating
      if (s.running) begin
         if (s.div == 8'(SAMPLE_DIV - 1)) begin
            next_s.div = 8'h00;
            strobe     = 1'b1;
         end else begin
            next_s.div = s.div + 8'h01;
         end
      end else begin
         next_s.div = 8'h00;
      end

      if (strobe) begin
         if (!s.bias_fix_enable) begin
            accept  = 1'b1;
            acc_bit = s.noise_s2;
         end else if (!s.have_prev) begin
            next_s.have_prev = 1'b1;
            next_s.prev_bit  = s.noise_s2;
         end else begin
            next_s.have_prev = 1'b0;
            accept  = (s.prev_bit != s.noise_s2);
            acc_bit = s.prev_bit;
         end
      end

      if (accept) begin
         new_byte         = {s.shift[6:0], acc_bit};
         next_s.shift     = new_byte;
         next_s.bit_count = s.bit_count + 3'h1;
         if (s.bit_count == 3'(`BYTE_BITS - 1)) begin
            byte_done    = 1'b1;
            next_s.value = new_byte;
         end
      end

      // start from stopped drops any partial byte so no stale bits leak in
      // start trigger
      if (start_hit && !s.running) begin
         next_s.running   = 1'b1;
         next_s.bit_count = 3'h0;
         next_s.have_prev = 1'b0;
      end
      if (stop_hit || (byte_done && s.ready_to_halt_shortcut)) begin
         next_s.running = 1'b0;
      end

      // register writes
      if (wr_acc && hit(bus_req.address, `OFS_AUTO_STOP_LINK)) begin
         next_s.ready_to_halt_shortcut = bus_req.writedata[`FLD_HALT_SHORTCUT];
      end
      if (wr_acc && hit(bus_req.address, `OFS_GENERATOR_SETUP)) begin
         next_s.bias_fix_enable = bus_req.writedata[`FLD_BIAS_FIX];
      end
      if (wr_acc && hit(bus_req.address, `OFS_IRQ_ENABLE_SET) && bus_req.writedata[`FLD_IRQ_SAMPLE_READY]) begin
         next_s.irq_en = 1'b1;
      end
      if (wr_acc && hit(bus_req.address, `OFS_IRQ_ENABLE_CLEAR) && bus_req.writedata[`FLD_IRQ_SAMPLE_READY]) begin
         next_s.irq_en = 1'b0;
      end

      // flag clear by write of one
      if (wr_acc && hit(bus_req.address, `OFS_SAMPLE_READY) && bus_req.writedata[`FLD_SAMPLE_READY]) begin
         next_s.sample_ready_flag = 1'b0;
      end
      // one event per byte, set wins
      if (byte_done) begin
         next_s.sample_ready_flag = 1'b1;
      end
      next_s.irq = next_s.sample_ready_flag && next_s.irq_en;

      // read data captured in the wait cycle
      // writes get a response too, so an unmapped write is reported
      if ((bus_req.read || bus_req.write) && s.rsp.waitrequest) begin
         next_s.rsp.readdata = `RST_WORD;
         next_s.rsp.response = `RESP_OKAY;
         case (1'b1)
            hit(bus_req.address, `OFS_START_TRIGGER),
            hit(bus_req.address, `OFS_STOP_TRIGGER): begin
               next_s.rsp.readdata = `RST_WORD;
            end
            hit(bus_req.address, `OFS_SAMPLE_READY): begin
               next_s.rsp.readdata = bit_word(s.sample_ready_flag);
            end
            hit(bus_req.address, `OFS_AUTO_STOP_LINK): begin
               next_s.rsp.readdata = bit_word(s.ready_to_halt_shortcut);
            end
            hit(bus_req.address, `OFS_IRQ_ENABLE_SET),
            hit(bus_req.address, `OFS_IRQ_ENABLE_CLEAR): begin
               next_s.rsp.readdata = bit_word(s.irq_en);
            end
            hit(bus_req.address, `OFS_GENERATOR_SETUP): begin
               next_s.rsp.readdata = bit_word(s.bias_fix_enable);
            end
            hit(bus_req.address, `OFS_RANDOM_OUTPUT): begin
               next_s.rsp.readdata = {24'h00_0000, s.value};
            end
            default: begin
               next_s.rsp.response = `RESP_DECODE_ERROR;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         s                 <= '0;
         s.value           <= `RST_BYTE;
         s.rsp.waitrequest <= 1'b1;
         s.rsp.readdata    <= `RST_WORD;
         s.rsp.response    <= `RESP_OKAY;
      end else begin
         s <= next_s;
      end
   end

   assign bus_rsp = s.rsp;
   assign irq     = s.irq;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);

   chk_start_runs: assert property (start_hit && !s.running |=> s.running)
      else $error("start trigger did not begin generation");

   chk_stop_halts: assert property (stop_hit |=> !s.running)
      else $error("stop trigger did not halt generation");

   chk_byte_loads: assert property (byte_done |=> s.value == $past(new_byte) && s.bit_count == 3'h0)
      else $error("completed byte not loaded into output register");

   chk_event_raised: assert property (byte_done |=> s.sample_ready_flag)
      else $error("byte loaded without sample-ready event");

   chk_value_only_on_event: assert property (!byte_done |=> s.value == $past(s.value))
      else $error("output register changed without a new byte");

   chk_flag_clear: assert property (wr_acc && hit(bus_req.address, `OFS_SAMPLE_READY)
                                    && bus_req.writedata[0] && !byte_done |=> !s.sample_ready_flag)
      else $error("flag not cleared by write");

   chk_short_halts: assert property (byte_done && s.ready_to_halt_shortcut |=> !s.running)
      else $error("shortcut did not stop generation");

   chk_irq_set: assert property (wr_one && hit(bus_req.address, `OFS_IRQ_ENABLE_SET) |=> s.irq_en)
      else $error("interrupt not enabled by set write");

   chk_irq_clear: assert property (wr_one && hit(bus_req.address, `OFS_IRQ_ENABLE_CLEAR)
                                   && !hit(bus_req.address, `OFS_IRQ_ENABLE_SET) |=> !s.irq_en)
      else $error("interrupt not disabled by clear write");

   chk_irq_level: assert property (##1 s.irq == (s.sample_ready_flag && s.irq_en))
      else $error("interrupt output disagrees with flag and enable");

   chk_stopped_quiet: assert property (!s.running |-> !byte_done)
      else $error("event raised while stopped");

   chk_bias_pairs: assert property (s.bias_fix_enable && strobe && !s.have_prev |-> !accept)
      else $error("bias correction accepted an unpaired bit");

   chk_bus_answer: assert property ((bus_req.read || bus_req.write) && s.rsp.waitrequest
                                    |=> !s.rsp.waitrequest ##1 s.rsp.waitrequest)
      else $error("bus answer not given after one wait cycle");

   // ----------------------------------------------------------------
   // read-back, configuration and datapath assertions
   // ----------------------------------------------------------------
   chk_trigger_reads_zero: assert property (bus_req.read && s.rsp.waitrequest
                                            && (hit(bus_req.address, `OFS_START_TRIGGER)
                                                || hit(bus_req.address, `OFS_STOP_TRIGGER))
                                            |=> s.rsp.readdata == `RST_WORD)
      else $error("trigger register did not read zero");

   chk_flag_reads_back: assert property (bus_req.read && s.rsp.waitrequest
                                         && hit(bus_req.address, `OFS_SAMPLE_READY)
                                         |=> s.rsp.readdata == {31'h0000_0000, $past(s.sample_ready_flag)})
      else $error("flag register read back a wrong value");

   chk_enable_reads_back: assert property (bus_req.read && s.rsp.waitrequest
                                           && (hit(bus_req.address, `OFS_IRQ_ENABLE_SET)
                                               || hit(bus_req.address, `OFS_IRQ_ENABLE_CLEAR))
                                           |=> s.rsp.readdata == {31'h0000_0000, $past(s.irq_en)})
      else $error("enable registers read back a wrong value");

   chk_output_low_byte: assert property (bus_req.read && s.rsp.waitrequest
                                         && hit(bus_req.address, `OFS_RANDOM_OUTPUT)
                                         |=> s.rsp.readdata == {24'h00_0000, $past(s.value)})
      else $error("output register read back a wrong value");

   chk_zero_set_inert: assert property (wr_acc && hit(bus_req.address, `OFS_IRQ_ENABLE_SET)
                                        && !bus_req.writedata[`FLD_IRQ_SAMPLE_READY]
                                        |=> s.irq_en == $past(s.irq_en))
      else $error("zero written to enable-set changed the enable");

   chk_setup_write: assert property (wr_acc && hit(bus_req.address, `OFS_GENERATOR_SETUP)
                                     |=> s.bias_fix_enable == $past(bus_req.writedata[`FLD_BIAS_FIX]))
      else $error("setup write did not set bias correction");

   chk_link_write: assert property (wr_acc && hit(bus_req.address, `OFS_AUTO_STOP_LINK)
                                    |=> s.ready_to_halt_shortcut == $past(bus_req.writedata[`FLD_HALT_SHORTCUT]))
      else $error("shortcut write did not land");

   chk_start_fresh: assert property (start_hit && !s.running |=> s.bit_count == 3'h0 && !s.have_prev)
      else $error("start kept a partial byte");

   chk_stopped_frozen: assert property (!s.running && !start_hit
                                        |=> s.bit_count == $past(s.bit_count) && s.value == $past(s.value))
      else $error("state moved while stopped");

   chk_raw_passthrough: assert property (!s.bias_fix_enable && strobe |-> accept && acc_bit == s.noise_s2)
      else $error("raw sample not taken with correction off");

   chk_equal_pair_drop: assert property (s.bias_fix_enable && strobe && s.have_prev
                                         && s.prev_bit == s.noise_s2 |-> !accept)
      else $error("equal pair was not discarded");

   chk_unequal_pair_keep: assert property (s.bias_fix_enable && strobe && s.have_prev
                                           && s.prev_bit != s.noise_s2 |-> accept && acc_bit == s.prev_bit)
      else $error("unequal pair did not give its first bit");

   chk_single_event: assert property (byte_done |=> !byte_done)
      else $error("two events for one byte");

   chk_sample_pace: assert property (s.running && s.div == 8'(SAMPLE_DIV - 1) |-> strobe)
      else $error("running generator skipped a sample");

   chk_idle_divider: assert property (!s.running |=> s.div == 8'h00)
      else $error("divider ran while stopped");

   chk_pin_sync: assert property (1'b1 |=> s.noise_s2 == $past(s.noise_s1))
      else $error("noise pin skipped a synchroniser stage");

   chk_irq_masked: assert property (!s.irq_en |-> !s.irq)
      else $error("interrupt high while disabled");

   cov_byte: cover property (byte_done);
   cov_short: cover property (byte_done && s.ready_to_halt_shortcut);
   cov_irq: cover property (!s.irq ##1 s.irq);
   cov_bias_byte: cover property (byte_done && s.bias_fix_enable);
   cov_stop_write: cover property (stop_hit && s.running);

endmodule
`default_nettype wire

/* File: inc/noise_byte_pkg.sv */
// types of the random byte source: bus request, bus answer and block state
// assumes noise_byte_regs.svh is compiled alongside
package noise_byte_pkg;

   typedef struct packed {
      logic        read;
      logic        write;
      logic [11:0] address;
      logic [31:0] writedata;
      logic [3:0]  byteenable;
   } avl_req_t;

   typedef struct packed {
      logic [31:0] readdata;
      logic        waitrequest;
      logic [1:0]  response;
   } avl_rsp_t;

   typedef struct packed {
      logic       noise_s1;
      logic       noise_s2;
      logic       running;
      logic [7:0] div;
      logic       have_prev;
      logic       prev_bit;
      logic [7:0] shift;
      logic [2:0] bit_count;
      logic [7:0] value;
      logic       sample_ready_flag;
      logic       ready_to_halt_shortcut;
      logic       irq_en;
      logic       bias_fix_enable;
      logic       irq;
      avl_rsp_t   rsp;
   } state_t;

endpackage

/* File: inc/noise_byte_regs.svh */
// register offsets, field positions, reset values and counts of the random byte source
// assumes byte addressing on a 32-bit register bus, one aligned word per register
`ifndef NOISE_BYTE_REGS_SVH
`define NOISE_BYTE_REGS_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define OFS_START_TRIGGER    12'h000
`define OFS_STOP_TRIGGER     12'h004
`define OFS_SAMPLE_READY     12'h100
`define OFS_AUTO_STOP_LINK   12'h200
`define OFS_IRQ_ENABLE_SET   12'h304
`define OFS_IRQ_ENABLE_CLEAR 12'h308
`define OFS_GENERATOR_SETUP  12'h504
`define OFS_RANDOM_OUTPUT    12'h508

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define FLD_TRIGGER          0
`define FLD_SAMPLE_READY     0
`define FLD_HALT_SHORTCUT    0
`define FLD_IRQ_SAMPLE_READY 0
`define FLD_BIAS_FIX         0
`define RST_WORD             32'h0000_0000
`define RST_BYTE             8'h00

// ----------------------------------------------------------------
// bus answers and timing counts
// ----------------------------------------------------------------
`define RESP_OKAY            2'h0
`define RESP_DECODE_ERROR    2'h3
`define SAMPLE_DIV_DEFAULT   8
`define BYTE_BITS            8

`endif

/* File: tb/true_random_byte_source_tb_top.sv */
// testbench of the random byte source: bus master tasks, noise driver, reference checks
// assumes the design files and noise_byte_regs.svh are on the include path
`timescale 1ns/1ps
`default_nettype none
`include "noise_byte_regs.svh"

module true_random_byte_source_tb_top;
   import noise_byte_pkg::*;

   logic        clk_sys;
   logic        rst_n;
   logic        noise_bit;
   avl_req_t    bus_req;
   avl_rsp_t    bus_rsp;
   logic        irq;
   int          err_count;
   int          total_checks;
   int          seed;
   int          cycles;
   int          noise_mode;
   bit          hist[$];
   logic [31:0] rd;
   logic [1:0]  rs;
   logic [7:0]  v;
   logic [11:0] reg_list[8];

   true_random_byte_source #(.SAMPLE_DIV(1)) DUT (.clk_sys(clk_sys), .rst_n(rst_n), .noise_bit(noise_bit),
      .bus_req(bus_req), .bus_rsp(bus_rsp), .irq(irq));

   // ----------------------------------------------------------------
   // clock, timeout and noise driver
   // ----------------------------------------------------------------
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end

   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         err_count++;
         tally_and_finish();
      end
   end

   // mode 0 holds the level, 1 random per cycle (kept in the history), 2 toggles
   always @(posedge clk_sys) begin
      logic [31:0] r;
      r = $random(seed);
      if (noise_mode == 1) begin
         noise_bit <= r[0];
         hist.push_back(r[0]);
      end else if (noise_mode == 2) begin
         noise_bit <= ~noise_bit;
      end
   end

   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic tally_and_finish;
      $display("checks=%0d mismatches=%0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] t=%0t %s got=%h exp=%h", $time, what, got, exp);
      end
   endtask

   // one Avalon transfer; upper write bits are random, bit 0 carries the value
   task automatic bus(input logic wr, input logic [11:0] a, input logic b);
      logic [31:0] r;
      r = $random(seed);
      @(posedge clk_sys);
      bus_req.read <= !wr;
      bus_req.write <= wr;
      bus_req.address <= a;
      bus_req.writedata <= {r[31:1], b};
      bus_req.byteenable <= 4'hf;
      do @(posedge clk_sys); while (bus_rsp.waitrequest !== 1'b0);
      rd = bus_rsp.readdata;
      rs = bus_rsp.response;
      bus_req.read <= 1'b0;
      bus_req.write <= 1'b0;
   endtask

   task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
      bus(1'b0, a, 1'b0);
      check(rd, exp, "read data");
      check(32'(rs), 32'(`RESP_OKAY), "response");
   endtask

   task automatic wait_flag;
      for (int i = 0; i < 100; i++) begin
         bus(1'b0, `OFS_SAMPLE_READY, 1'b0);
         if (rd[0] === 1'b1) break;
      end
      check(rd, 32'h1, "sample ready flag");
   endtask

   function automatic bit in_hist(input logic [7:0] b);
      logic [7:0] w;
      for (int i = 0; i + 8 <= hist.size(); i++) begin
         for (int k = 0; k < 8; k++) w[7-k] = hist[i+k];
         if (w === b) return 1'b1;
      end
      return 1'b0;
   endfunction

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      seed = 74726;
      rst_n = 1'b0;
      noise_bit = 1'b0;
      noise_mode = 0;
      bus_req = '0;
      reg_list = '{`OFS_START_TRIGGER, `OFS_STOP_TRIGGER, `OFS_SAMPLE_READY, `OFS_AUTO_STOP_LINK,
                   `OFS_IRQ_ENABLE_SET, `OFS_IRQ_ENABLE_CLEAR, `OFS_GENERATOR_SETUP, `OFS_RANDOM_OUTPUT};
      repeat (10) @(posedge clk_sys);
      rst_n <= 1'b1;
      foreach (reg_list[i]) rdchk(reg_list[i], `RST_WORD);
      bus(1'b0, 12'hffc, 1'b0);
      check(32'(rs), 32'(`RESP_DECODE_ERROR), "unmapped response");
      check(rd, 32'h0, "unmapped data");
      $display("test reset_values done");

      bus(1'b1, `OFS_IRQ_ENABLE_SET, 1'b0);
      rdchk(`OFS_IRQ_ENABLE_SET, 32'h0);
      bus(1'b1, `OFS_IRQ_ENABLE_SET, 1'b1);
      rdchk(`OFS_IRQ_ENABLE_CLEAR, 32'h1);
      bus(1'b1, `OFS_IRQ_ENABLE_CLEAR, 1'b1);
      rdchk(`OFS_IRQ_ENABLE_SET, 32'h0);
      bus(1'b1, `OFS_IRQ_ENABLE_SET, 1'b1);
      check(32'(irq), 32'h0, "irq idle");
      $display("test irq_enable done");

      noise_mode = 1;
      bus(1'b1, `OFS_START_TRIGGER, 1'b1);
      wait_flag();
      check(32'(irq), 32'h1, "irq on byte");
      bus(1'b1, `OFS_SAMPLE_READY, 1'b1);
      wait_flag();
      bus(1'b1, `OFS_STOP_TRIGGER, 1'b1);
      bus(1'b0, `OFS_RANDOM_OUTPUT, 1'b0);
      v = rd[7:0];
      check(32'(in_hist(v)), 32'h1, "byte from noise");
      check(32'(rd[31:8]), 32'h0, "upper bits");
      bus(1'b1, `OFS_SAMPLE_READY, 1'b1);
      repeat (50) @(posedge clk_sys);
      rdchk(`OFS_SAMPLE_READY, 32'h0);
      rdchk(`OFS_RANDOM_OUTPUT, {24'h0, v});
      check(32'(irq), 32'h0, "irq after clear");
      $display("test run_stop done");

      bus(1'b1, `OFS_IRQ_ENABLE_CLEAR, 1'b1);
      bus(1'b1, `OFS_AUTO_STOP_LINK, 1'b1);
      rdchk(`OFS_AUTO_STOP_LINK, 32'h1);
      bus(1'b1, `OFS_START_TRIGGER, 1'b1);
      wait_flag();
      check(32'(irq), 32'h0, "irq masked");
      bus(1'b0, `OFS_RANDOM_OUTPUT, 1'b0);
      v = rd[7:0];
      bus(1'b1, `OFS_SAMPLE_READY, 1'b1);
      repeat (50) @(posedge clk_sys);
      rdchk(`OFS_SAMPLE_READY, 32'h0);
      rdchk(`OFS_RANDOM_OUTPUT, {24'h0, v});
      bus(1'b1, `OFS_AUTO_STOP_LINK, 1'b0);
      $display("test shortcut done");

      bus(1'b1, `OFS_GENERATOR_SETUP, 1'b1);
      rdchk(`OFS_GENERATOR_SETUP, 32'h1);
      noise_mode = 2;
      bus(1'b1, `OFS_START_TRIGGER, 1'b1);
      wait_flag();
      bus(1'b1, `OFS_STOP_TRIGGER, 1'b1);
      bus(1'b0, `OFS_RANDOM_OUTPUT, 1'b0);
      check(32'(rd == 32'h0 || rd == 32'hff), 32'h1, "paired toggling byte");
      bus(1'b1, `OFS_SAMPLE_READY, 1'b1);
      noise_mode = 0;
      bus(1'b1, `OFS_START_TRIGGER, 1'b1);
      repeat (200) @(posedge clk_sys);
      rdchk(`OFS_SAMPLE_READY, 32'h0);
      bus(1'b1, `OFS_STOP_TRIGGER, 1'b1);
      bus(1'b1, `OFS_GENERATOR_SETUP, 1'b0);
      bus(1'b1, `OFS_START_TRIGGER, 1'b1);
      wait_flag();
      bus(1'b1, `OFS_STOP_TRIGGER, 1'b1);
      rdchk(`OFS_RANDOM_OUTPUT, {24'h0, {8{noise_bit}}});
      $display("test bias_fix done");
      tally_and_finish();
   end

endmodule
`default_nettype wire
